// ### common/tmv_pkg.sv
// constants and carrier types for the timer match, flag and trigger control block
package tmv_pkg;
	// register select codes on the cpu register port
	localparam logic [1:0] REG_STATUS = 2'h0; // match_status_output_select
	localparam logic [1:0] REG_TRIG = 2'h1; // trigger_clock_control
	localparam logic [1:0] REG_CTL0 = 2'h2; // clock_clear_irq_control
	// match_status_output_select fields
	localparam int BIT_FLAG_B = 7;
	localparam int BIT_FLAG_A = 6;
	localparam int BIT_WRAP = 5;
	localparam int BIT_STAT_RSV = 4;
	localparam int BIT_OSB_HI = 3;
	localparam int BIT_OSB_LO = 2;
	localparam int BIT_OSA_HI = 1;
	localparam int BIT_OSA_LO = 0;
	// trigger_clock_control fields
	localparam int BIT_TRIG_HI = 4;
	localparam int BIT_TRIG_LO = 3;
	localparam int BIT_TRIG_START_ENABLE = 2;
	localparam int BIT_TRIG_RSV = 1;
	localparam int BIT_CLK_EXTRA = 0;
	localparam logic [2:0] TRIG_RSV_HI = 3'h7; // bits 7 to 5 read as one
	// clock_clear_irq_control fields
	localparam int BIT_IEN_B = 7;
	localparam int BIT_IEN_A = 6;
	localparam int BIT_IEN_WRAP = 5;
	localparam int BIT_CCLR_HI = 4;
	localparam int BIT_CCLR_LO = 3;
	localparam int BIT_CKS_HI = 2;
	localparam int BIT_CKS_LO = 0;
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [2:0] RST_FLAGS = 3'h0;
	localparam logic [1:0] RST_SEL2 = 2'h0;
	localparam logic RST_BIT = 1'b0;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	// two bit output action codes
	localparam logic [1:0] OUT_HOLD = 2'h0;
	localparam logic [1:0] OUT_LOW = 2'h1;
	localparam logic [1:0] OUT_HIGH = 2'h2;
	localparam logic [1:0] OUT_TOGGLE = 2'h3;
	// two bit edge select codes, shared by trigger pin and external clock
	localparam logic [1:0] EDGE_NONE = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	localparam int NUM_TAPS = 6; // divided clocks /4 up to /128
	// one register port request
	typedef struct packed {
		logic rd;
		logic wr;
		logic [1:0] sel;
		logic [7:0] wdata;
	} tmv_req_s;
	// events from the counter datapath
	typedef struct packed {
		logic match_a;
		logic match_b;
		logic wrap;
		logic cleared;
	} tmv_evt_s;
endpackage : tmv_pkg

// ### core/tmv_ctl.sv
// status flags, waveform output, trigger start and clock select for the 8-bit timer
`timescale 1ns/100ps
// Function
// [RL1] set match b flag, bit 7, when counter equals constant b
// [RL2] set match a flag, bit 6, when counter equals constant a
// [RL3] flags clear only by reading one then writing zero
// [RL4] set wrap flag, bit 5, when counter wraps from ff to 00
// [RL5] status bit 4 always reads one
// [RL6] trigger control bits 7 to 5 and bit 1 read one
// [RL7] match b drives pin per bits 3:2: hold, low, high, toggle
// [RL8] match a drives pin per bits 1:0 with same coding
// [RL9] each match uses only its own output select field
// [RL10] waveform pin is zero after reset until first match
// [RL11] trigger edge select: none, rising, falling, both
// [RL12] trigger enable set: start on edge, halt on counter clear
// [RL13] trigger enable clear: ignore edges, keep counting after clear
// [RL14] extra clock select bit joins the three clock select bits
// [RL15] clock: divided /4 to /128 falling edge, or external pin edges
// [RL16] interrupt request when a flag and its enable are both set
// [RL17] with trigger enabled halt at once on clear, resume on edge
// [RL18] same cycle matches: toggle beats high beats low
// [RL19] hardware set beats a same cycle software clear
// [RL20] trigger pin synchronised and edges found from sampled levels
module tmv_ctl (
	input wire logic clk,
	input wire logic rst,
	input tmv_pkg::tmv_req_s req,
	input tmv_pkg::tmv_evt_s evt,
	input wire logic trig_pin,
	input wire logic ext_clk_pin,
	input wire logic [tmv_pkg::NUM_TAPS-1:0] presc_tap,
	output logic [7:0] rdata,
	output logic wave_out_pin,
	output logic irq,
	output logic count_run,
	output logic count_tick,
	output logic [1:0] clear_sel
);
	import tmv_pkg::*;

	// decode of an edge select code against detected edges
	function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
		edge_hit = ((sel == EDGE_RISE) & rise) | ((sel == EDGE_FALL) & fall) | ((sel == EDGE_BOTH) & (rise | fall));
	endfunction : edge_hit

	logic match_b_flag;
	logic match_a_flag;
	logic wrap_flag;
	logic [2:0] armed;
	logic [1:0] out_sel_b;
	logic [1:0] out_sel_a;
	logic [1:0] trig_edge_sel;
	logic trig_start_enable;
	logic clock_sel_extra;
	logic [2:0] irq_en;
	logic [2:0] clock_sel;
	logic run_flag;
	logic tap_prev;
	logic trig_rise;
	logic trig_fall;
	logic ext_rise;
	logic ext_fall;

	// synchronised trigger and external clock pins
	tmv_edge u_trig_edge (.clk(clk), .rst(rst), .pin_in(trig_pin), .rise(trig_rise), .fall(trig_fall)); // RL20
	tmv_edge u_ext_edge (.clk(clk), .rst(rst), .pin_in(ext_clk_pin), .rise(ext_rise), .fall(ext_fall));

	// register port decode
	wire wr_status = req.wr & (req.sel == REG_STATUS);
	wire wr_trig = req.wr & (req.sel == REG_TRIG);
	wire wr_ctl0 = req.wr & (req.sel == REG_CTL0);
	wire rd_status = req.rd & (req.sel == REG_STATUS);

	// flag order b, a, wrap; clear needs prior read as one then a zero write
	wire [2:0] hw_set = {evt.match_b, evt.match_a, evt.wrap}; // RL1 RL2 RL4
	wire [2:0] wr_zero = ~req.wdata[BIT_FLAG_B:BIT_WRAP];
	wire [2:0] sw_clr = {3{wr_status}} & armed & wr_zero; // RL3
	wire [2:0] cur_flags = {match_b_flag, match_a_flag, wrap_flag};
	wire [2:0] next_flags = hw_set | (cur_flags & ~sw_clr); // RL19

	// per match output action, each from its own field
	wire [1:0] act_b = evt.match_b ? out_sel_b : OUT_HOLD; // RL7 RL9
	wire [1:0] act_a = evt.match_a ? out_sel_a : OUT_HOLD; // RL8 RL9
	wire any_toggle = (act_a == OUT_TOGGLE) | (act_b == OUT_TOGGLE);
	wire any_high = (act_a == OUT_HIGH) | (act_b == OUT_HIGH);
	wire any_low = (act_a == OUT_LOW) | (act_b == OUT_LOW);
	wire next_wave = any_toggle ? ~wave_out_pin : any_high ? 1'b1 : any_low ? 1'b0 : wave_out_pin; // RL18

	// trigger start and halt on clear
	wire trig_hit = trig_start_enable & edge_hit(trig_edge_sel, trig_rise, trig_fall); // RL11
	wire next_run_flag = trig_hit | (run_flag & ~evt.cleared); // RL12 RL17
	wire next_run = ~trig_start_enable | (next_run_flag & ~(evt.cleared & ~trig_hit)); // RL13

	// count clock selection from the four select bits
	wire [3:0] clk_code = {clock_sel, clock_sel_extra}; // RL14
	// two taps per code, the extra bit picking the slower of the pair
	wire [2:0] tap_idx = {clk_code[2:1] - 2'h1, clk_code[0]};
	wire tap_ok = ~clk_code[3] & (clk_code[2:1] != 2'h0);
	wire tap_level = tap_ok ? presc_tap[tap_idx] : 1'b0;
	wire int_tick = tap_ok & tap_prev & ~tap_level; // RL15
	wire ext_tick = clock_sel[2] & edge_hit(clock_sel[1:0], ext_rise, ext_fall); // RL15
	wire next_tick = (int_tick | ext_tick) & next_run;

	// read mux
	wire [7:0] rd_status_v = {match_b_flag, match_a_flag, wrap_flag, 1'b1, out_sel_b, out_sel_a}; // RL5
	wire [7:0] rd_trig_v = {TRIG_RSV_HI, trig_edge_sel, trig_start_enable, 1'b1, clock_sel_extra}; // RL6
	wire [7:0] rd_ctl0_v = {irq_en, clear_sel, clock_sel};
	wire [7:0] next_rdata = (req.sel == REG_STATUS) ? rd_status_v : (req.sel == REG_TRIG) ? rd_trig_v :
		(req.sel == REG_CTL0) ? rd_ctl0_v : UNMAPPED_READ;

	// status flags and the read-armed record
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			{match_b_flag, match_a_flag, wrap_flag} <= RST_FLAGS;
			armed <= RST_FLAGS;
		end else begin
			{match_b_flag, match_a_flag, wrap_flag} <= next_flags;
			armed <= rd_status ? cur_flags : (wr_status ? RST_FLAGS : armed); // RL3
		end
	end

	// software control fields
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			{out_sel_b, out_sel_a} <= {RST_SEL2, RST_SEL2};
			{trig_edge_sel, trig_start_enable, clock_sel_extra} <= {RST_SEL2, RST_BIT, RST_BIT};
			{irq_en, clear_sel, clock_sel} <= RST_BYTE;
		end else begin
			if (wr_status) {out_sel_b, out_sel_a} <= req.wdata[BIT_OSB_HI:BIT_OSA_LO];
			if (wr_trig) begin
				trig_edge_sel <= req.wdata[BIT_TRIG_HI:BIT_TRIG_LO];
				trig_start_enable <= req.wdata[BIT_TRIG_START_ENABLE];
				clock_sel_extra <= req.wdata[BIT_CLK_EXTRA];
			end
			if (wr_ctl0) {irq_en, clear_sel, clock_sel} <= req.wdata;
		end
	end

	// outputs and run state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wave_out_pin <= RST_BIT; // RL10
			run_flag <= RST_BIT;
			count_run <= RST_BIT;
			count_tick <= RST_BIT;
			tap_prev <= RST_BIT;
			irq <= RST_BIT;
			rdata <= RST_BYTE;
		end else begin
			wave_out_pin <= next_wave;
			run_flag <= next_run_flag;
			count_run <= next_run;
			count_tick <= next_tick;
			tap_prev <= tap_level;
			irq <= |(next_flags & irq_en); // RL16
			rdata <= req.rd ? next_rdata : rdata;
		end
	end

	// checks
	chk_flag_b_set: assert property (@(posedge clk) disable iff (rst) evt.match_b |=> match_b_flag) // RL1
		else $error("match b did not set its flag");
	chk_flag_a_set: assert property (@(posedge clk) disable iff (rst) evt.match_a |=> match_a_flag) // RL2
		else $error("match a did not set its flag");
	chk_flag_clear: assert property (@(posedge clk) disable iff (rst) $fell(match_b_flag) |-> // RL3
		$past(wr_status) && !$past(req.wdata[BIT_FLAG_B]) && $past(armed[2])) else $error("flag b cleared illegally");
	chk_wrap_set: assert property (@(posedge clk) disable iff (rst) evt.wrap |=> wrap_flag) // RL4
		else $error("wrap did not set its flag");
	chk_status_rsv: assert property (@(posedge clk) disable iff (rst) rd_status |=> rdata[BIT_STAT_RSV]) // RL5
		else $error("status reserved bit read zero");
	chk_trig_rsv: assert property (@(posedge clk) disable iff (rst) req.rd && req.sel == REG_TRIG |=> // RL6
		rdata[7:5] == TRIG_RSV_HI && rdata[BIT_TRIG_RSV]) else $error("trigger reserved bits not one");
	chk_toggle_b: assert property (@(posedge clk) disable iff (rst) // RL7
		evt.match_b && !evt.match_a && out_sel_b == OUT_TOGGLE |=> wave_out_pin != $past(wave_out_pin))
		else $error("match b toggle missed");
	chk_drive_a: assert property (@(posedge clk) disable iff (rst) // RL8
		evt.match_a && !evt.match_b && out_sel_a == OUT_LOW |=> !wave_out_pin) else $error("match a low missed");
	chk_prio_high: assert property (@(posedge clk) disable iff (rst) // RL18
		evt.match_a && evt.match_b && out_sel_a == OUT_LOW && out_sel_b == OUT_HIGH |=> wave_out_pin)
		else $error("high did not beat low");
	chk_halt_clear: assert property (@(posedge clk) disable iff (rst) // RL12
		trig_start_enable && evt.cleared && !trig_hit |=> !count_run && !count_tick) else $error("no halt on clear");
	chk_free_run: assert property (@(posedge clk) disable iff (rst) !trig_start_enable |=> count_run) // RL13
		else $error("counter halted with trigger disabled");
	chk_set_wins: assert property (@(posedge clk) disable iff (rst) evt.match_a && sw_clr[1] |=> match_a_flag) // RL19
		else $error("set lost to clear");
	// flag clears on the other two flags
	chk_flag_a_clear: assert property (@(posedge clk) disable iff (rst) $fell(match_a_flag) |-> // RL3
		$past(wr_status) && !$past(req.wdata[BIT_FLAG_A]) && $past(armed[1])) else $error("flag a cleared illegally");
	chk_wrap_clear: assert property (@(posedge clk) disable iff (rst) $fell(wrap_flag) |-> // RL3
		$past(wr_status) && !$past(req.wdata[BIT_WRAP]) && $past(armed[0]))
		else $error("wrap flag cleared illegally");
	chk_irq_level: assert property (@(posedge clk) disable iff (rst) // RL16
		1'b1 |=> irq == |(cur_flags & $past(irq_en))) else $error("irq level wrong");
	// waveform pin moves only on a match, by that match's own field
	chk_wave_idle: assert property (@(posedge clk) disable iff (rst) !evt.match_a && !evt.match_b |=> // RL9
		$stable(wave_out_pin)) else $error("waveform moved without a match");
	chk_own_field: assert property (@(posedge clk) disable iff (rst) // RL9
		evt.match_a && !evt.match_b && out_sel_a == OUT_HOLD |=> $stable(wave_out_pin))
		else $error("match a used the other field");
	chk_high_b: assert property (@(posedge clk) disable iff (rst) // RL7
		evt.match_b && !evt.match_a && out_sel_b == OUT_HIGH |=> wave_out_pin) else $error("match b high missed");
	chk_low_b: assert property (@(posedge clk) disable iff (rst) // RL7
		evt.match_b && !evt.match_a && out_sel_b == OUT_LOW |=> !wave_out_pin) else $error("match b low missed");
	chk_toggle_a: assert property (@(posedge clk) disable iff (rst) // RL8
		evt.match_a && !evt.match_b && out_sel_a == OUT_TOGGLE |=> wave_out_pin != $past(wave_out_pin))
		else $error("match a toggle missed");
	// a halted counter stays halted until a selected edge arrives
	chk_edge_off: assert property (@(posedge clk) disable iff (rst) // RL11
		trig_start_enable && trig_edge_sel == EDGE_NONE && !count_run |=> !count_run)
		else $error("start taken with trigger edges off");
	chk_wait_edge: assert property (@(posedge clk) disable iff (rst) // RL17
		trig_start_enable && !count_run && !trig_hit |=> !count_run)
		else $error("counter resumed without a trigger edge");
	chk_tick_halt: assert property (@(posedge clk) disable iff (rst) !count_run |-> !count_tick) // RL12
		else $error("tick while halted");
	chk_no_clock: assert property (@(posedge clk) disable iff (rst) clock_sel[1:0] == 2'h0 |=> !count_tick) // RL15
		else $error("tick with clock input prohibited");
	// coverage of the main scenarios
	cov_trig_start: cover property (@(posedge clk) disable iff (rst) !count_run ##1 trig_hit ##1 count_run);
	cov_flag_cleared: cover property (@(posedge clk) disable iff (rst) rd_status && match_a_flag ##[1:4] sw_clr[1]);
	cov_both_match: cover property (@(posedge clk) disable iff (rst) evt.match_a && evt.match_b);
	cov_ext_tick: cover property (@(posedge clk) disable iff (rst) clock_sel[2] && count_tick);
	cov_set_wins: cover property (@(posedge clk) disable iff (rst) evt.match_a && sw_clr[1]);
endmodule : tmv_ctl

// ### core/tmv_edge.sv
// two flop synchroniser with rise and fall detection
`timescale 1ns/100ps
module tmv_edge (
	input wire logic clk,
	input wire logic rst,
	input wire logic pin_in,
	output logic rise,
	output logic fall
);
	logic sync1;
	logic sync2;
	logic prev;
	// sync1 feeds only sync2; edges come from later stages
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			prev <= 1'b0;
		end else begin
			sync1 <= pin_in;
			sync2 <= sync1;
			prev <= sync2;
		end
	end
	// compare successive sampled levels
	assign rise = sync2 & ~prev;
	assign fall = ~sync2 & prev;
endmodule : tmv_edge

// ### dv/testbench.sv
// self-checking bench for the timer match, flag and trigger control block
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin miscompares++; $display("BAD %s exp %h got %h", nm, ex, got); end end
module testbench;
	import tmv_pkg::*;
	logic clk, rst, want_lvl, wave_out_pin, irq, count_run, count_tick;
	logic [7:0] rdata, rv, wave_edges, div;
	logic [1:0] clear_sel;
	tmv_req_s req;
	tmv_evt_s evt;
	wire logic trig_pin;
	int miscompares, checks, cycles, ticks;
	tmv_ctl tmv_ctl_inst (.clk(clk), .rst(rst), .req(req), .evt(evt), .trig_pin(trig_pin), .ext_clk_pin(div[2]),
		.presc_tap(div[6:1]), .rdata(rdata), .wave_out_pin(wave_out_pin), .irq(irq), .count_run(count_run),
		.count_tick(count_tick), .clear_sel(clear_sel));
	tmv_partner tmv_partner_inst (.clk(clk), .want_lvl(want_lvl), .wave_out_pin(wave_out_pin),
		.trig_pin(trig_pin), .wave_edges(wave_edges));
	// 25 mhz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// free-running divider standing in for the prescaler taps and the external count clock
	always @(posedge clk) div <= #1 div + 8'h01;
	// tick counter and hang guard
	always @(posedge clk) begin
		cycles++;
		if (count_tick === 1'b1) ticks++;
		if (cycles == 4000) begin
			miscompares++;
			give_verdict();
		end
	end
	task automatic give_verdict;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : give_verdict
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic wr(input logic [1:0] s, input logic [7:0] d);
		req = '{rd: 1'b0, wr: 1'b1, sel: s, wdata: d};
		cyc(1);
		req.wr = 1'b0;
		cyc(1);
	endtask : wr
	task automatic rd(input logic [1:0] s);
		req = '{rd: 1'b1, wr: 1'b0, sel: s, wdata: 8'h00};
		cyc(1);
		req.rd = 1'b0;
		rv = rdata;
		cyc(1);
	endtask : rd
	task automatic ev(input logic a, input logic b, input logic w, input logic c);
		evt = '{match_a: a, match_b: b, wrap: w, cleared: c};
		cyc(1);
		evt = '0;
		cyc(1);
	endtask : ev
	// reset levels, fixed one bits and the unmapped select
	task automatic t_reset;
		`CHK("wave_rst", 1'b0, wave_out_pin)
		rd(REG_STATUS);
		`CHK("status_rst", 8'h10, rv)
		wr(REG_TRIG, 8'h00);
		rd(REG_TRIG);
		`CHK("trig_fixed", 8'he2, rv)
		wr(2'h3, 8'hff);
		rd(2'h3);
		`CHK("unmapped", 8'h00, rv)
		wr(REG_CTL0, 8'hb9);
		`CHK("clear_sel", 2'h3, clear_sel)
		rd(REG_CTL0);
		`CHK("ctl0_back", 8'hb9, rv)
		$display("t_reset done");
	endtask : t_reset
	// flags set by events, cleared only after being read as one
	task automatic t_flags;
		wr(REG_CTL0, 8'h40);
		ev(1'b1, 1'b1, 1'b1, 1'b0);
		`CHK("irq_a", 1'b1, irq)
		rd(REG_STATUS);
		`CHK("flags_set", 8'hf0, rv)
		wr(REG_STATUS, 8'h00);
		rd(REG_STATUS);
		`CHK("flags_clr", 8'h10, rv)
		`CHK("irq_clr", 1'b0, irq)
		ev(1'b0, 1'b0, 1'b1, 1'b0);
		wr(REG_STATUS, 8'h00);
		rd(REG_STATUS);
		`CHK("clr_unread", 8'h30, rv)
		ev(1'b1, 1'b0, 1'b0, 1'b0);
		rd(REG_STATUS);
		`CHK("flags_rd", 8'h70, rv)
		// clearing write and a new match a in the same cycle
		req = '{rd: 1'b0, wr: 1'b1, sel: REG_STATUS, wdata: 8'h00};
		evt = '{match_a: 1'b1, match_b: 1'b0, wrap: 1'b0, cleared: 1'b0};
		cyc(1);
		req = '0;
		evt = '0;
		cyc(1);
		rd(REG_STATUS);
		`CHK("set_wins", 8'h50, rv)
		$display("t_flags done");
	endtask : t_flags
	// output codes per match, independence and same-cycle priority
	task automatic t_wave;
		logic [10:0] tw [8] = '{11'h015, 11'h00c, 11'h01d, 11'h005, 11'h022, 11'h05b, 11'h03e, 11'h04f};
		for (int i = 0; i < 8; i++) begin
			wr(REG_STATUS, tw[i][10:3]);
			ev(tw[i][2], tw[i][1], 1'b0, 1'b0);
			`CHK("wave", tw[i][0], wave_out_pin)
		end
		cyc(2);
		`CHK("load_edges", 8'h07, wave_edges)
		$display("t_wave done");
	endtask : t_wave
	// halt on clear and restart on the selected trigger edge only
	task automatic t_trig;
		logic [1:0] c;
		for (int i = 1; i < 4; i++) begin
			c = i[1:0];
			want_lvl = (c == EDGE_RISE);
			cyc(6);
			wr(REG_TRIG, {3'h0, c, 3'h4});
			ev(1'b0, 1'b0, 1'b0, 1'b1);
			`CHK("halt", 1'b0, count_run)
			want_lvl = ~want_lvl;
			cyc(8);
			`CHK("edge_sel", c == EDGE_BOTH, count_run)
			if (c != EDGE_BOTH) begin
				want_lvl = ~want_lvl;
				cyc(8);
				`CHK("start", 1'b1, count_run)
			end
		end
		wr(REG_TRIG, 8'h04);
		ev(1'b0, 1'b0, 1'b0, 1'b1);
		want_lvl = ~want_lvl;
		cyc(8);
		`CHK("edges_off", 1'b0, count_run)
		wr(REG_TRIG, 8'h00);
		ev(1'b0, 1'b0, 1'b0, 1'b1);
		cyc(2);
		`CHK("no_halt", 1'b1, count_run)
		$display("t_trig done");
	endtask : t_trig
	// tick rate for divided and external clocks and the two prohibited codes
	task automatic t_clk;
		logic [2:0] ck [6] = '{3'h1, 3'h1, 3'h0, 3'h4, 3'h5, 3'h7};
		logic ex [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
		int et [6] = '{10, 5, 0, 0, 5, 10};
		for (int i = 0; i < 6; i++) begin
			wr(REG_CTL0, {5'h00, ck[i]});
			wr(REG_TRIG, {7'h00, ex[i]});
			cyc(8);
			ticks = 0;
			cyc(40);
			`CHK("ticks", et[i], ticks)
		end
		$display("t_clk done");
	endtask : t_clk
	// reset, then the scenarios in turn
	initial begin
		rst = 1'b1;
		req = '0;
		evt = '0;
		want_lvl = 1'b0;
		div = 8'h00;
		miscompares = 0;
		checks = 0;
		cycles = 0;
		ticks = 0;
		repeat (3) @(posedge clk);
		#1 rst = 1'b0;
		cyc(1);
		t_reset();
		t_flags();
		t_wave();
		t_trig();
		t_clk();
		give_verdict();
	end
endmodule : testbench

// ### dv/tmv_partner.sv
// trigger source and pulse load model facing the timer control block
`timescale 1ns/100ps
module tmv_partner (
	input wire logic clk,
	input wire logic want_lvl,
	input wire logic wave_out_pin,
	output logic trig_pin,
	output logic [7:0] wave_edges
);
	logic last_wave;
	// trigger source: moves the pin a little after a clock edge and then holds the level
	always @(posedge clk) trig_pin <= #1 want_lvl;
	// pulse load: counts every level change it sees on the waveform pin
	always @(posedge clk) begin
		last_wave <= wave_out_pin;
		if (wave_out_pin !== last_wave) wave_edges <= wave_edges + 8'h01;
	end
	// quiet pin and empty count at start
	initial begin
		trig_pin = 1'b0;
		wave_edges = 8'h00;
		last_wave = 1'b0;
	end
endmodule : tmv_partner
